/* design/ccr_pkg.sv */
// Summary of operation
// - 8-bit accumulator, also read and written as data address FFh.
// - First index pointer at data 80h, second at 81h.
// - First short-direct register at 82h, second at 83h.
// - Index pointers drive indirect operand addresses and act as data registers.
// - 12-bit program counter addresses 4096 bytes of program space.
// - Memory beyond 4096 bytes uses a bank-switch register, not a wider counter.
// - Counter increments after fetch; relative branch adds or subtracts offset and writes back.
// - Counter loads target, offset sum, vector, or popped value; holds on a hold request; else adds one.
// - Three carry/zero pairs: main, interrupt, urgent.
// - Interrupt or urgent entry selects its pair; interrupt exit restores previous, or main if the stack is empty.
// - Pairs are never cleared on switching; only the active pair is accessed.
// - Carry follows arithmetic carry/borrow, tested bit, or rotate-left shift-out.
// - Zero is set when the last arithmetic or logic result is zero.
// - After reset the urgent context and its flags are active.
// - Six-level 12-bit return stack outside data space, no pointer, no data saved.
// - Call or interrupt entry shifts levels up, counter into level one.
// - Return moves level one into counter and shifts levels down.
// - Beyond six nestings the oldest return address is silently lost.
// - Return on empty stack keeps stack at top and runs next instruction.
package ccr_pkg;
   localparam logic [7:0] CCR_ADDR_IDX1 = 8'h80;
   localparam logic [7:0] CCR_ADDR_IDX2 = 8'h81;
   localparam logic [7:0] CCR_ADDR_SD1 = 8'h82;
   localparam logic [7:0] CCR_ADDR_SD2 = 8'h83;
   localparam logic [7:0] CCR_ADDR_ACC = 8'hFF;
   localparam int CCR_PC_W = 12;
   localparam int CCR_STACK_DEPTH = 6;
   localparam logic [7:0] CCR_DATA_RST = 8'h00;
   localparam logic [11:0] CCR_PC_RST = 12'h000;
   localparam logic [11:0] CCR_PC_ONE = 12'h001;

   typedef enum logic [1:0] {
      CCR_CTX_MAIN,
      CCR_CTX_INT,
      CCR_CTX_URGENT
   } ccr_ctx_e;

   typedef enum logic [2:0] {
      CCR_PC_NEXT,
      CCR_PC_JUMP,
      CCR_PC_REL,
      CCR_PC_VECTOR,
      CCR_PC_CALL,
      CCR_PC_RET,
      CCR_PC_HOLD
   } ccr_pcop_e;

   typedef enum logic [1:0] {
      CCR_ENT_NONE,
      CCR_ENT_INT,
      CCR_ENT_URGENT
   } ccr_entry_e;

   // Program counter request from the sequencer
   typedef struct packed {
      ccr_pcop_e op;
      logic [11:0] target;
      logic [7:0] offset;
      logic backward;
      ccr_entry_e entry;
      logic int_exit;
   } ccr_pcreq_s;

   // Flag update request from the ALU
   typedef struct packed {
      logic carry_we;
      logic carry_val;
      logic zero_we;
      logic zero_val;
   } ccr_flagreq_s;

   // Data-space access
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccr_dreq_s;
endpackage

/* design/ccr_core_regs.sv */
`timescale 1ns/10ps
module ccr_core_regs
   import ccr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire ccr_pcreq_s PC_REQ,
   input wire ccr_flagreq_s FLAG_REQ,
   input wire ccr_dreq_s DATA_REQ,
   input wire logic ACC_WE,
   input wire logic [7:0] ACC_WDATA,
   output logic [11:0] PC,
   output logic [7:0] ACC,
   output logic [7:0] IDX1,
   output logic [7:0] IDX2,
   output logic [7:0] SD1,
   output logic [7:0] SD2,
   output logic [7:0] RDATA,
   output logic RHIT,
   output logic CARRY,
   output logic ZERO,
   output ccr_ctx_e CTX
);
   logic [11:0] pc_reg;
   logic [11:0] pc_next;
   logic [7:0] acc_reg, idx1_reg, idx2_reg, sd1_reg, sd2_reg;
   logic [7:0] rdata_reg;
   logic rhit_reg;
   logic [2:0] carry_reg, zero_reg;
   logic carry_out_reg, zero_out_reg;
   ccr_ctx_e ctx_reg, ctx_next;
   logic [11:0] stk_reg [0:CCR_STACK_DEPTH-1];
   ccr_ctx_e cstk_reg [0:CCR_STACK_DEPTH-1];
   logic [2:0] depth_reg;

   // Register decode; shared with the read mux
   wire hit_acc = DATA_REQ.addr == CCR_ADDR_ACC;
   wire hit_idx1 = DATA_REQ.addr == CCR_ADDR_IDX1;
   wire hit_idx2 = DATA_REQ.addr == CCR_ADDR_IDX2;
   wire hit_sd1 = DATA_REQ.addr == CCR_ADDR_SD1;
   wire hit_sd2 = DATA_REQ.addr == CCR_ADDR_SD2;
   wire hit_any = hit_acc | hit_idx1 | hit_idx2 | hit_sd1 | hit_sd2;
   wire [7:0] rd_mux = hit_acc ? acc_reg : hit_idx1 ? idx1_reg :
      hit_idx2 ? idx2_reg : hit_sd1 ? sd1_reg : hit_sd2 ? sd2_reg :
      CCR_DATA_RST;

   // Stack movement; pop on empty leaves the stack alone
   wire push = PC_REQ.op == CCR_PC_CALL || PC_REQ.op == CCR_PC_VECTOR;
   wire is_ret = PC_REQ.op == CCR_PC_RET;
   wire pop = is_ret && depth_reg != 3'h0;
   // Offset sign-free add or subtract through the 12-bit counter
   wire [11:0] off12 = {4'h0, PC_REQ.offset};
   wire [11:0] rel_sum = PC_REQ.backward ? pc_reg - off12
                                         : pc_reg + off12;
   wire [1:0] ci = ctx_reg; // Active pair index

   // One flag bit of the active pair replaced; other pairs pass untouched
   function automatic logic [2:0] ccr_pair_upd(logic [2:0] cur,
      logic [1:0] idx, logic we, logic val);
      logic [2:0] res;
      res = cur;
      if (we)
         res[idx] = val;
      return res;
   endfunction

   // Counter source select; counter width never grows, banks live elsewhere
   always_comb begin
      unique case (PC_REQ.op)
         CCR_PC_NEXT: pc_next = pc_reg + CCR_PC_ONE;
         CCR_PC_JUMP: pc_next = PC_REQ.target;
         CCR_PC_CALL: pc_next = PC_REQ.target;
         CCR_PC_REL: pc_next = rel_sum;
         CCR_PC_VECTOR: pc_next = PC_REQ.target;
         CCR_PC_RET: pc_next = pop ? stk_reg[0] : pc_reg + CCR_PC_ONE;
         CCR_PC_HOLD: pc_next = pc_reg;
         default: pc_next = pc_reg;
      endcase
   end

   // Context switch; a plain return never changes flags context
   always_comb begin
      ctx_next = ctx_reg;
      if (PC_REQ.op == CCR_PC_VECTOR && PC_REQ.entry == CCR_ENT_INT)
         ctx_next = CCR_CTX_INT;
      else if (PC_REQ.op == CCR_PC_VECTOR && PC_REQ.entry == CCR_ENT_URGENT)
         ctx_next = CCR_CTX_URGENT;
      else if (is_ret && PC_REQ.int_exit)
         ctx_next = pop ? cstk_reg[0] : CCR_CTX_MAIN;
   end

   // Next pair values and the pair that becomes active after this edge
   wire [2:0] carry_next = ccr_pair_upd(carry_reg, ci, FLAG_REQ.carry_we,
      FLAG_REQ.carry_val);
   wire [2:0] zero_next = ccr_pair_upd(zero_reg, ci, FLAG_REQ.zero_we,
      FLAG_REQ.zero_val);
   wire [1:0] cn = ctx_next; // Pair index after a context switch

   // Counter and context
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pc_reg <= CCR_PC_RST;
         ctx_reg <= CCR_CTX_URGENT;
      end else begin
         pc_reg <= pc_next;
         ctx_reg <= ctx_next;
      end
   end

   // Return stack shift; oldest level falls off the end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         depth_reg <= 3'h0;
         for (int i = 0; i < CCR_STACK_DEPTH; i++) begin
            stk_reg[i] <= CCR_PC_RST;
            cstk_reg[i] <= CCR_CTX_MAIN;
         end
      end else if (push) begin
         stk_reg[0] <= pc_reg;
         cstk_reg[0] <= ctx_reg;
         for (int i = 1; i < CCR_STACK_DEPTH; i++) begin
            stk_reg[i] <= stk_reg[i-1];
            cstk_reg[i] <= cstk_reg[i-1];
         end
         if (depth_reg != 3'(CCR_STACK_DEPTH))
            depth_reg <= depth_reg + 3'h1;
      end else if (pop) begin
         for (int i = 0; i < CCR_STACK_DEPTH - 1; i++) begin
            stk_reg[i] <= stk_reg[i+1];
            cstk_reg[i] <= cstk_reg[i+1];
         end
         depth_reg <= depth_reg - 3'h1;
      end
   end

   // Flags: only the active pair moves, others keep their values.
   // The visible flags are flopped from the next pair so that the
   // outputs stay glitch-free across a context switch.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         carry_reg <= 3'h0;
         zero_reg <= 3'h0;
         carry_out_reg <= 1'b0;
         zero_out_reg <= 1'b0;
      end else begin
         carry_reg <= carry_next;
         zero_reg <= zero_next;
         carry_out_reg <= carry_next[cn];
         zero_out_reg <= zero_next[cn];
      end
   end

   // Data registers; ALU write of the accumulator wins over data space
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         acc_reg <= CCR_DATA_RST;
         idx1_reg <= CCR_DATA_RST;
         idx2_reg <= CCR_DATA_RST;
         sd1_reg <= CCR_DATA_RST;
         sd2_reg <= CCR_DATA_RST;
         rdata_reg <= CCR_DATA_RST;
         rhit_reg <= 1'b0;
      end else begin
         if (ACC_WE)
            acc_reg <= ACC_WDATA;
         else if (DATA_REQ.we && hit_acc)
            acc_reg <= DATA_REQ.wdata;
         if (DATA_REQ.we && hit_idx1)
            idx1_reg <= DATA_REQ.wdata;
         if (DATA_REQ.we && hit_idx2)
            idx2_reg <= DATA_REQ.wdata;
         if (DATA_REQ.we && hit_sd1)
            sd1_reg <= DATA_REQ.wdata;
         if (DATA_REQ.we && hit_sd2)
            sd2_reg <= DATA_REQ.wdata;
         rdata_reg <= rd_mux;
         rhit_reg <= hit_any;
      end
   end

   // Outputs are flops; pointers feed indirect addressing directly
   assign PC = pc_reg;
   assign ACC = acc_reg;
   assign IDX1 = idx1_reg;
   assign IDX2 = idx2_reg;
   assign SD1 = sd1_reg;
   assign SD2 = sd2_reg;
   assign RDATA = rdata_reg;
   assign RHIT = rhit_reg;
   assign CARRY = carry_out_reg;
   assign ZERO = zero_out_reg;
   assign CTX = ctx_reg;

   AST_RESET_URGENT: assert property (@(posedge CLK)
      $rose(RESET_N) |-> ctx_reg == CCR_CTX_URGENT)
      else $error("context not urgent after reset");
   AST_PC_INC: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_NEXT |=> pc_reg == $past(pc_reg) + CCR_PC_ONE)
      else $error("counter did not advance by one");
   AST_PC_JUMP: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_JUMP |=> pc_reg == $past(PC_REQ.target))
      else $error("jump target not loaded");
   AST_PUSH_L1: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_CALL |=> stk_reg[0] == $past(pc_reg))
      else $error("call did not save counter");
   AST_POP_PC: assert property (@(posedge CLK) disable iff (!RESET_N)
      is_ret && depth_reg != 3'h0 |=> pc_reg == $past(stk_reg[0]))
      else $error("return did not pop counter");
   AST_EMPTY_RET: assert property (@(posedge CLK) disable iff (!RESET_N)
      is_ret && depth_reg == 3'h0 |=> depth_reg == 3'h0 &&
      pc_reg == $past(pc_reg) + CCR_PC_ONE)
      else $error("empty return misbehaved");
   AST_DEPTH_CAP: assert property (@(posedge CLK) disable iff (!RESET_N)
      depth_reg <= 3'(CCR_STACK_DEPTH))
      else $error("stack depth overflow");
   AST_INT_CTX: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_VECTOR && PC_REQ.entry == CCR_ENT_INT
      |=> ctx_reg == CCR_CTX_INT ##0 cstk_reg[0] == $past(ctx_reg))
      else $error("interrupt entry context wrong");
   AST_FLAG_KEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
      ctx_reg != CCR_CTX_MAIN |=> carry_reg[0] == $past(carry_reg[0]))
      else $error("inactive pair changed");
   AST_ACC_MIRROR: assert property (@(posedge CLK) disable iff (!RESET_N)
      DATA_REQ.we && hit_acc && !ACC_WE |=> acc_reg == $past(DATA_REQ.wdata))
      else $error("accumulator mirror write lost");

   // Further checks on counter sources, stack movement, flag pairs and data registers
   AST_CALL_PC: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_CALL |=> pc_reg == $past(PC_REQ.target))
      else $error("call target not loaded");

   AST_VEC_PC: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_VECTOR |=> pc_reg == $past(PC_REQ.target))
      else $error("vector not loaded");

   AST_REL_FWD: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_REL && !PC_REQ.backward
      |=> pc_reg == 12'($past(pc_reg) + $past(off12)))
      else $error("forward branch sum wrong");

   AST_REL_BACK: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_REL && PC_REQ.backward
      |=> pc_reg == 12'($past(pc_reg) - $past(off12)))
      else $error("backward branch sum wrong");

   AST_URG_CTX: assert property (@(posedge CLK) disable iff (!RESET_N)
      PC_REQ.op == CCR_PC_VECTOR && PC_REQ.entry == CCR_ENT_URGENT
      |=> ctx_reg == CCR_CTX_URGENT)
      else $error("urgent entry context wrong");

   AST_INTERRUPT_EXIT_CTX: assert property (@(posedge CLK) disable iff (!RESET_N)
      is_ret && PC_REQ.int_exit && depth_reg != 3'h0
      |=> ctx_reg == $past(cstk_reg[0]))
      else $error("interrupt exit context not restored");

   AST_PUSH_SHIFT: assert property (@(posedge CLK) disable iff (!RESET_N)
      push |=> stk_reg[1] == $past(stk_reg[0]))
      else $error("push did not shift levels");

   AST_POP_SHIFT: assert property (@(posedge CLK) disable iff (!RESET_N)
      pop |=> stk_reg[0] == $past(stk_reg[1]))
      else $error("pop did not shift levels");

   AST_DEPTH_SAT: assert property (@(posedge CLK) disable iff (!RESET_N)
      push && depth_reg == 3'(CCR_STACK_DEPTH)
      |=> depth_reg == 3'(CCR_STACK_DEPTH))
      else $error("full stack depth moved");

   AST_CARRY_OUT: assert property (@(posedge CLK) disable iff (!RESET_N)
      CARRY == carry_reg[ci])
      else $error("carry output not from active pair");

   AST_ZERO_OUT: assert property (@(posedge CLK) disable iff (!RESET_N)
      ZERO == zero_reg[ci])
      else $error("zero output not from active pair");

   AST_CARRY_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
      FLAG_REQ.carry_we
      |=> carry_reg[$past(ci)] == $past(FLAG_REQ.carry_val))
      else $error("carry write lost");

   AST_ZERO_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
      FLAG_REQ.zero_we
      |=> zero_reg[$past(ci)] == $past(FLAG_REQ.zero_val))
      else $error("zero write lost");

   AST_IDX1_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
      DATA_REQ.we && hit_idx1 |=> idx1_reg == $past(DATA_REQ.wdata))
      else $error("first pointer write lost");

   AST_SD2_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
      DATA_REQ.we && hit_sd2 |=> sd2_reg == $past(DATA_REQ.wdata))
      else $error("second short-direct write lost");

   AST_ACC_PRIO: assert property (@(posedge CLK) disable iff (!RESET_N)
      ACC_WE |=> acc_reg == $past(ACC_WDATA))
      else $error("accumulator write lost");

   AST_RHIT: assert property (@(posedge CLK) disable iff (!RESET_N)
      hit_any |=> rhit_reg)
      else $error("mapped read not flagged");

   AST_RD_IDX2: assert property (@(posedge CLK) disable iff (!RESET_N)
      hit_idx2 |=> rdata_reg == $past(idx2_reg))
      else $error("second pointer read wrong");

endmodule

/* bench/ccr_seq_model.sv */
`timescale 1ns/10ps
module ccr_seq_model
   import ccr_pkg::*;
(
   input wire logic CLK,
   output ccr_pcreq_s PC_REQ,
   output ccr_flagreq_s FLAG_REQ,
   output ccr_dreq_s DATA_REQ,
   output logic ACC_WE,
   output logic [7:0] ACC_WDATA
);
   // Quiet cycle: counter held so each result stands for the bench
   task automatic idle();
      PC_REQ = '{CCR_PC_HOLD, 12'h000, 8'h00, 1'h0, CCR_ENT_NONE, 1'h0};
      FLAG_REQ = '0;
      DATA_REQ = '0;
      {ACC_WE, ACC_WDATA} = 9'h000;
   endtask
   initial idle();
   // Relative offset rides in t[7:0], direction in t[11]
   task automatic pc(ccr_pcop_e op, logic [11:0] t, ccr_entry_e e, logic x);
      @(negedge CLK);
      PC_REQ = '{op, t, t[7:0], t[11], e, x};
      @(negedge CLK);
      idle();
   endtask
   // ALU result: flag writes and an optional accumulator write
   task automatic fa(logic [3:0] f, logic [8:0] a);
      @(negedge CLK);
      FLAG_REQ = f;
      {ACC_WE, ACC_WDATA} = a;
      @(negedge CLK);
      idle();
   endtask
   // Data-space access, write enable then address then data
   task automatic dw(logic [16:0] r);
      @(negedge CLK);
      DATA_REQ = r;
      @(negedge CLK);
      idle();
   endtask
endmodule

/* bench/ccr_core_regs_test.sv */
`timescale 1ns/10ps
module ccr_core_regs_test;
   import ccr_pkg::*;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   ccr_pcreq_s pc_req;
   ccr_flagreq_s flag_req;
   ccr_dreq_s data_req;
   logic acc_we, rhit, carry, zero;
   logic [7:0] acc_wdata, acc, idx1, idx2, sd1, sd2, rdata;
   logic [11:0] pc_q;
   ccr_ctx_e ctx;
   int n_errors = 0;
   int check_count = 0;
   logic [7:0] at [5] = '{CCR_ADDR_IDX1, CCR_ADDR_IDX2, CCR_ADDR_SD1,
      CCR_ADDR_SD2, CCR_ADDR_ACC};
   // 100 ns core clock
   always #50 clk = ~clk;
   ccr_core_regs i_ccr_core_regs (.CLK(clk), .RESET_N(reset_n),
      .PC_REQ(pc_req), .FLAG_REQ(flag_req), .DATA_REQ(data_req),
      .ACC_WE(acc_we), .ACC_WDATA(acc_wdata), .PC(pc_q), .ACC(acc),
      .IDX1(idx1), .IDX2(idx2), .SD1(sd1), .SD2(sd2), .RDATA(rdata),
      .RHIT(rhit), .CARRY(carry), .ZERO(zero), .CTX(ctx));
   ccr_seq_model i_ccr_seq_model (.CLK(clk), .PC_REQ(pc_req),
      .FLAG_REQ(flag_req), .DATA_REQ(data_req), .ACC_WE(acc_we),
      .ACC_WDATA(acc_wdata));
   task automatic chk(logic [11:0] got, logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Context and active flag pair compared as one value
   task automatic cf(ccr_ctx_e e, logic c, logic z);
      chk({8'h00, ctx, carry, zero}, {8'h00, e, c, z});
   endtask
   task automatic pc(ccr_pcop_e op, logic [11:0] t);
      i_ccr_seq_model.pc(op, t, CCR_ENT_NONE, 1'h0);
   endtask
   // Nested entries must bring back the pair in use before each
   task automatic t_ctx();
      cf(CCR_CTX_URGENT, 1'h0, 1'h0);
      chk(pc_q, CCR_PC_RST);
      i_ccr_seq_model.fa(4'hE, 9'h000);
      cf(CCR_CTX_URGENT, 1'h1, 1'h0);
      i_ccr_seq_model.pc(CCR_PC_RET, 12'h000, CCR_ENT_NONE, 1'h1);
      cf(CCR_CTX_MAIN, 1'h0, 1'h0);
      chk(pc_q, CCR_PC_ONE);
      i_ccr_seq_model.fa(4'hB, 9'h000);
      cf(CCR_CTX_MAIN, 1'h0, 1'h1);
      i_ccr_seq_model.pc(CCR_PC_VECTOR, 12'h040, CCR_ENT_INT, 1'h0);
      cf(CCR_CTX_INT, 1'h0, 1'h0);
      i_ccr_seq_model.fa(4'hF, 9'h000);
      i_ccr_seq_model.pc(CCR_PC_VECTOR, 12'h080, CCR_ENT_URGENT, 1'h0);
      cf(CCR_CTX_URGENT, 1'h1, 1'h0);
      i_ccr_seq_model.pc(CCR_PC_RET, 12'h000, CCR_ENT_NONE, 1'h1);
      cf(CCR_CTX_INT, 1'h1, 1'h1);
      chk(pc_q, 12'h040);
      i_ccr_seq_model.pc(CCR_PC_RET, 12'h000, CCR_ENT_NONE, 1'h1);
      cf(CCR_CTX_MAIN, 1'h0, 1'h1);
      chk(pc_q, CCR_PC_ONE);
   endtask
   // Counter updates, wrapping at the 12-bit boundary both ways
   task automatic t_pc();
      pc(CCR_PC_NEXT, 12'h000);
      chk(pc_q, 12'h002);
      pc(CCR_PC_JUMP, 12'hFFF);
      chk(pc_q, 12'hFFF);
      pc(CCR_PC_NEXT, 12'h000);
      chk(pc_q, 12'h000);
      pc(CCR_PC_REL, 12'h010);
      chk(pc_q, 12'h010);
      pc(CCR_PC_REL, 12'h820);
      chk(pc_q, 12'hFF0);
   endtask
   // Seven calls overflow six levels, then unwind past empty
   task automatic t_stack();
      pc(CCR_PC_JUMP, 12'h100);
      for (int i = 1; i <= 7; i++) begin
         pc(CCR_PC_CALL, 12'h200 + 12'(i));
      end
      chk(pc_q, 12'h207);
      for (int i = 6; i >= 1; i--) begin
         pc(CCR_PC_RET, 12'h000);
         chk(pc_q, 12'h200 + 12'(i));
      end
      pc(CCR_PC_RET, 12'h000);
      chk(pc_q, 12'h202);
      cf(CCR_CTX_MAIN, 1'h0, 1'h1);
   endtask
   // Mapped writes, read-back, ALU path and a stray address
   task automatic t_data();
      for (int i = 0; i < 5; i++) begin
         i_ccr_seq_model.dw({1'h1, at[i], 8'hA0 + 8'(i)});
      end
      chk({idx1, sd2[3:0]}, 12'hA03);
      chk({idx2, sd1[3:0]}, 12'hA12);
      i_ccr_seq_model.dw({1'h1, 8'h84, 8'h55});
      for (int i = 0; i < 5; i++) begin
         i_ccr_seq_model.dw({1'h0, at[i], 8'h00});
         chk({3'h0, rhit, rdata}, {4'h1, 8'hA0 + 8'(i)});
      end
      i_ccr_seq_model.fa(4'h0, 9'h13C);
      i_ccr_seq_model.dw({1'h0, CCR_ADDR_ACC, 8'h00});
      chk({acc, rdata[3:0]}, 12'h3CC);
      i_ccr_seq_model.dw({1'h0, 8'h84, 8'h00});
      chk({3'h0, rhit, rdata}, 12'h000);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog: the scenarios need fewer than a hundred cycles
   initial begin
      #(100 * 2000);
      n_errors++;
      report_and_stop();
   end
   // Reset for five cycles, then the scenarios in order
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'h1;
      t_ctx();
      t_pc();
      t_stack();
      t_data();
      report_and_stop();
   end
endmodule
